/* src/cmc_params.svh */
// Functional notes
// - Stop-in-idle bit 13 set halts the module while the chip is idle.
// - Writing 1 to bit 12 aborts all pending sends; it self-clears afterwards.
// - Bit 11 selects module clock: 1 is twice the peripheral clock, 0 equal.
// - Mode request bits 10-8: 0 normal,1 disable,2 loop,3 listen,4 config,7 all.
// - Read-only bits 7-5 report the actual mode, same codes as the request.
// - Bit 3 set makes each received message raise a capture event.
// - Bit 0 selects the shared window: 1 filter registers, 0 buffer registers.
// - Bits 15-14, 4 and 2-1 of control read as zero and ignore writes.
// - Filter pointer 1111 routes to the receive FIFO, 0000-1110 to buffer 0-14.
`ifndef CMC_PARAMS_SVH
`define CMC_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CMC_ADDR_CONTROL_ONE 4'h0
`define CMC_ADDR_BUFFER_PNT4 4'h1

// ------------------------------------------------------------
// Control register field positions
// ------------------------------------------------------------
`define CMC_BIT_STOP_IDLE    13
`define CMC_BIT_ABORT        12
`define CMC_BIT_CLK_SEL      11
`define CMC_REQ_HI           10
`define CMC_REQ_LO           8
`define CMC_CUR_HI           7
`define CMC_CUR_LO           5
`define CMC_BIT_CAPTURE      3
`define CMC_BIT_WINDOW       0
`define CMC_CTRL_UNUSED_MASK 16'hC016

// ------------------------------------------------------------
// Mode codes and reset values
// ------------------------------------------------------------
`define CMC_MODE_NORMAL      3'h0
`define CMC_MODE_DISABLE     3'h1
`define CMC_MODE_LOOPBACK    3'h2
`define CMC_MODE_LISTEN_ONLY 3'h3
`define CMC_MODE_CONFIG      3'h4
`define CMC_MODE_RSVD_A      3'h5
`define CMC_MODE_RSVD_B      3'h6
`define CMC_MODE_LISTEN_ALL  3'h7
`define CMC_RESET_MODE       3'h4
`define CMC_RESET_POINTERS   16'h0000
`define CMC_PTR_TO_FIFO      4'hF

`endif

/* src/cmc_pkg.sv */
package cmc_pkg;

    // --------------------------------------------------------
    // Writable control fields
    // --------------------------------------------------------
    typedef struct packed {
        logic       stop_in_idle;
        logic       abort_all_transmit;
        logic       module_clock_source_select;
        logic [2:0] requested_operation_mode;
        logic       receive_capture_enable;
        logic       window_select;
    } cmc_control_type;

    // --------------------------------------------------------
    // Register bus request
    // --------------------------------------------------------
    typedef struct packed {
        logic        write;
        logic        read;
        logic [3:0]  address;
        logic [15:0] wdata;
    } cmc_bus_type;

endpackage

/* src/cmc_regs.sv */
`timescale 1ns/100ps
`include "cmc_params.svh"

module cmc_regs #(
    parameter int NUM_FILTERS = 4
) (
    // Clock and reset
    input  wire logic                   i_clock,
    input  wire logic                   i_reset_n,
    // Register port
    input  wire cmc_pkg::cmc_bus_type   i_bus,
    output logic [15:0]                 o_rdata,
    // Module status inputs
    input  wire logic                   i_device_idle,
    input  wire logic                   i_tx_pending,
    input  wire logic                   i_switch_safe,
    input  wire logic                   i_rx_message_done,
    // Module controls
    output logic                        o_module_halted,
    output logic                        o_abort_request,
    output logic                        o_clock_double,
    output logic [2:0]                  o_current_mode,
    output logic                        o_capture_event,
    output logic                        o_filter_window,
    output logic [NUM_FILTERS-1:0]      o_to_fifo,
    output logic [NUM_FILTERS*4-1:0]    o_buffer_pointers
);

    // --------------------------------------------------------
    // Decode
    // --------------------------------------------------------
    logic wr_ctrl;
    logic wr_pnt;
    assign wr_ctrl = i_bus.write && i_bus.address == `CMC_ADDR_CONTROL_ONE;
    assign wr_pnt  = i_bus.write && i_bus.address == `CMC_ADDR_BUFFER_PNT4;

    // --------------------------------------------------------
    // Control register
    // --------------------------------------------------------
    cmc_pkg::cmc_control_type ctrl_d, ctrl_q;
    logic [2:0]               mode_d, mode_q;
    logic                     legal_req;

    always_comb begin
        ctrl_d    = ctrl_q;
        mode_d    = mode_q;
        legal_req = ctrl_q.requested_operation_mode != `CMC_MODE_RSVD_A &&
                    ctrl_q.requested_operation_mode != `CMC_MODE_RSVD_B;
        // Abort ends once nothing is pending; a fresh write still wins.
        if (ctrl_q.abort_all_transmit && !i_tx_pending) begin
            ctrl_d.abort_all_transmit = 1'b0;
        end
        if (wr_ctrl) begin
            ctrl_d.stop_in_idle = i_bus.wdata[`CMC_BIT_STOP_IDLE];
            if (i_bus.wdata[`CMC_BIT_ABORT]) begin
                ctrl_d.abort_all_transmit = 1'b1;
            end
            ctrl_d.module_clock_source_select =
                i_bus.wdata[`CMC_BIT_CLK_SEL];
            ctrl_d.requested_operation_mode =
                i_bus.wdata[`CMC_REQ_HI:`CMC_REQ_LO];
            ctrl_d.receive_capture_enable =
                i_bus.wdata[`CMC_BIT_CAPTURE];
            ctrl_d.window_select = i_bus.wdata[`CMC_BIT_WINDOW];
        end
        // Reserved codes are stored but never entered, so the mode holds.
        if (legal_req && i_switch_safe) begin
            mode_d = ctrl_q.requested_operation_mode;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q <= '{requested_operation_mode: `CMC_RESET_MODE,
                        default: 1'b0};
            mode_q <= `CMC_RESET_MODE;
        end else begin
            ctrl_q <= ctrl_d;
            mode_q <= mode_d;
        end
    end

    // --------------------------------------------------------
    // Filter buffer pointers
    // --------------------------------------------------------
    logic [NUM_FILTERS*4-1:0] pnt_d, pnt_q;
    logic [NUM_FILTERS-1:0]   fifo_d, fifo_q;

    always_comb begin
        pnt_d = pnt_q;
        if (wr_pnt) begin
            pnt_d = i_bus.wdata[NUM_FILTERS*4-1:0];
        end
    end

    // Routing flags lag the pointer by a cycle so outputs stay registered.
    for (genvar g = 0; g < NUM_FILTERS; g++) begin : g_route
        assign fifo_d[g] = pnt_q[g*4 +: 4] == `CMC_PTR_TO_FIFO;
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pnt_q  <= `CMC_RESET_POINTERS;
            fifo_q <= '0;
        end else begin
            pnt_q  <= pnt_d;
            fifo_q <= fifo_d;
        end
    end

    // --------------------------------------------------------
    // Outputs and read data
    // --------------------------------------------------------
    logic [15:0] rdata_d, rdata_q;
    logic        halt_d, halt_q;
    logic        cap_d, cap_q;

    always_comb begin
        rdata_d = 16'h0000;
        if (i_bus.read && i_bus.address == `CMC_ADDR_CONTROL_ONE) begin
            // Unused positions are never assigned, so they read zero.
            rdata_d[`CMC_BIT_STOP_IDLE] = ctrl_q.stop_in_idle;
            rdata_d[`CMC_BIT_ABORT]     = ctrl_q.abort_all_transmit;
            rdata_d[`CMC_BIT_CLK_SEL]   = ctrl_q.module_clock_source_select;
            rdata_d[`CMC_REQ_HI:`CMC_REQ_LO] =
                ctrl_q.requested_operation_mode;
            rdata_d[`CMC_CUR_HI:`CMC_CUR_LO] = mode_q;
            rdata_d[`CMC_BIT_CAPTURE] = ctrl_q.receive_capture_enable;
            rdata_d[`CMC_BIT_WINDOW]  = ctrl_q.window_select;
        end else if (i_bus.read && i_bus.address == `CMC_ADDR_BUFFER_PNT4) begin
            rdata_d[NUM_FILTERS*4-1:0] = pnt_q;
        end
        halt_d = ctrl_q.stop_in_idle && i_device_idle;
        cap_d  = ctrl_q.receive_capture_enable && i_rx_message_done;
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_q <= 16'h0000;
            halt_q  <= 1'b0;
            cap_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            halt_q  <= halt_d;
            cap_q   <= cap_d;
        end
    end

    assign o_rdata           = rdata_q;
    assign o_module_halted   = halt_q;
    assign o_abort_request   = ctrl_q.abort_all_transmit;
    assign o_clock_double    = ctrl_q.module_clock_source_select;
    assign o_current_mode    = mode_q;
    assign o_capture_event   = cap_q;
    assign o_filter_window   = ctrl_q.window_select;
    assign o_to_fifo         = fifo_q;
    assign o_buffer_pointers = pnt_q;

    // --------------------------------------------------------
    // Checks
    // --------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    idle_halt_a: assert property (
        ctrl_q.stop_in_idle && i_device_idle |=> o_module_halted)
        else $error("module not halted in idle");
    idle_run_a: assert property (
        !ctrl_q.stop_in_idle |=> !o_module_halted)
        else $error("module halted with stop bit clear");
    abort_done_a: assert property (
        o_abort_request && !i_tx_pending &&
        !(wr_ctrl && i_bus.wdata[`CMC_BIT_ABORT]) |=> !o_abort_request)
        else $error("abort bit did not self clear");
    abort_set_a: assert property (
        wr_ctrl && i_bus.wdata[`CMC_BIT_ABORT] |=> o_abort_request)
        else $error("abort write lost");
    clock_select_a: assert property (
        wr_ctrl |=> o_clock_double == $past(i_bus.wdata[`CMC_BIT_CLK_SEL]))
        else $error("clock select not taken");
    mode_enter_a: assert property (
        wr_ctrl && i_bus.wdata[`CMC_REQ_HI:`CMC_REQ_LO] == `CMC_MODE_LOOPBACK
        ##1 i_switch_safe |=> o_current_mode == `CMC_MODE_LOOPBACK)
        else $error("requested mode not entered");
    reserved_mode_a: assert property (
        !legal_req |=> $stable(o_current_mode))
        else $error("reserved mode entered");
    status_read_a: assert property (
        i_bus.read && i_bus.address == `CMC_ADDR_CONTROL_ONE
        |=> o_rdata[`CMC_CUR_HI:`CMC_CUR_LO] == $past(o_current_mode))
        else $error("mode status misread");
    capture_event_a: assert property (
        o_capture_event |-> $past(ctrl_q.receive_capture_enable &&
                                  i_rx_message_done))
        else $error("capture event without cause");
    window_sel_a: assert property (
        wr_ctrl |=> o_filter_window == $past(i_bus.wdata[`CMC_BIT_WINDOW]))
        else $error("window select not taken");
    // Only control reads are held to the mask; pointer reads use every bit.
    unused_zero_a: assert property (
        i_bus.read && i_bus.address == `CMC_ADDR_CONTROL_ONE
        |=> (o_rdata & `CMC_CTRL_UNUSED_MASK) == 16'h0000)
        else $error("unused control bit read as one");
    capture_off_a: assert property (
        !ctrl_q.receive_capture_enable |=> !o_capture_event)
        else $error("capture event while disabled");
    pointer_write_a: assert property (
        wr_pnt |=> o_buffer_pointers ==
                   $past(i_bus.wdata[NUM_FILTERS*4-1:0]))
        else $error("buffer pointers not written");
    fifo_route_a: assert property (
        wr_pnt && i_bus.wdata[3:0] == `CMC_PTR_TO_FIFO ##1 !wr_pnt
        |=> o_to_fifo[0])
        else $error("filter not routed to fifo");

    mode_switch_c: cover property (
        $changed(o_current_mode) && o_current_mode == `CMC_MODE_NORMAL);
    abort_done_c: cover property (o_abort_request ##1 !o_abort_request);
    capture_c: cover property (o_capture_event);
    halt_c: cover property (o_module_halted);
    fifo_route_c: cover property (|o_to_fifo);

endmodule

/* verification/can_mode_control_regs_test.sv */
`timescale 1ns/100ps
module can_mode_control_regs_test;
    logic                 i_clock;
    logic                 i_reset_n;
    cmc_pkg::cmc_bus_type bus;
    logic [15:0]          rdata;
    logic [15:0]          ptrs;
    logic [3:0]           to_fifo;
    logic [2:0]           mode;
    logic [2:0]           prev;
    logic                 idle, load, safe, rx, pend, sw_safe, rx_done;
    logic                 halted, abort_req, clk_dbl, cap, win;
    int                   errors;
    int                   cmp_count;
    int                   cycles;

    cmc_regs DUT (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_bus(bus),
        .o_rdata(rdata), .i_device_idle(idle), .i_tx_pending(pend),
        .i_switch_safe(sw_safe), .i_rx_message_done(rx_done),
        .o_module_halted(halted), .o_abort_request(abort_req),
        .o_clock_double(clk_dbl), .o_current_mode(mode),
        .o_capture_event(cap), .o_filter_window(win), .o_to_fifo(to_fifo),
        .o_buffer_pointers(ptrs));
    cmc_can_partner far (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_load(load), .i_safe(safe), .i_rx(rx),
        .i_abort_request(abort_req), .o_tx_pending(pend),
        .o_switch_safe(sw_safe), .o_rx_done(rx_done));

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic check(input string n, input logic [15:0] e,
                         input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // The strobe stays up so a second access can follow with no gap.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus <= {1'b1, 1'b0, a, d};
        @(posedge i_clock);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e,
                      input string n);
        bus <= {1'b0, 1'b1, a, 16'h0000};
        @(posedge i_clock);
        bus <= '0;
        #1 check(n, e, rdata);
        @(posedge i_clock);
    endtask
    task automatic complete_run;
        if (errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        bus = '0;
        idle = 1'h0;
        load = 1'h0;
        safe = 1'h0;
        rx = 1'h0;
        i_reset_n = 1'h0;
        errors = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (5) @(posedge i_clock);
        i_reset_n <= 1'b1;
        load <= 1'b1;
        @(posedge i_clock);
        load <= 1'b0;
        rd(4'h0, 16'h0480, "reset control");
        rd(4'h1, 16'h0000, "reset pointers");
        wr(4'h0, 16'hFFFF);
        rd(4'h0, 16'h3F89, "control ones");
        #1 check("outs", 16'h000F, {clk_dbl, win, abort_req, mode == 3'h4});
        for (int n = 0; n < 20 && abort_req !== 1'b0; n++) begin
            @(posedge i_clock);
            #1;
        end
        check("abort done", 16'h0000, {15'h0, abort_req});
        @(posedge i_clock);
        rd(4'h0, 16'h2F89, "abort cleared");
        idle <= 1'b1;
        repeat (2) @(posedge i_clock);
        #1 check("halted", 16'h0001, {15'h0, halted});
        @(posedge i_clock);
        idle <= 1'b0;
        safe <= 1'b1;
        prev = 3'h4;
        for (int c = 0; c < 8; c++) begin
            wr(4'h0, {5'h00, 3'(c), 8'h00});
            bus <= '0;
            repeat (3) @(posedge i_clock);
            if (c != 5 && c != 6) prev = 3'(c);
            rd(4'h0, {5'h00, 3'(c), prev, 5'h00}, "mode");
        end
        idle <= 1'b1;
        for (int e = 1; e >= 0; e--) begin
            wr(4'h0, {12'h000, 1'(e), 3'h0});
            bus <= '0;
            rx <= 1'b1;
            @(posedge i_clock);
            rx <= 1'b0;
            @(posedge i_clock);
            #1 check("capture", 16'(e), {15'h0, cap});
            check("idle run", 16'h0000, {15'h0, halted});
            @(posedge i_clock);
            #1 check("capture pulse", 16'h0000, {15'h0, cap});
            @(posedge i_clock);
        end
        wr(4'h1, 16'hF3EF);
        wr(4'h5, 16'hFFFF);
        rd(4'h5, 16'h0000, "unmapped");
        rd(4'h1, 16'hF3EF, "pointers");
        #1 check("fifo map", 16'h0009, {12'h000, to_fifo});
        check("ptr out", 16'hF3EF, ptrs);
        check("window", 16'h0000, {clk_dbl, win});
        complete_run();
    end
endmodule

/* verification/cmc_can_partner.sv */
`timescale 1ns/100ps
module cmc_can_partner #(
    parameter int ABORT_DELAY = 6
) (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_reset_n,
    // Bench commands
    input  wire logic i_load,
    input  wire logic i_safe,
    input  wire logic i_rx,
    // Device side
    input  wire logic i_abort_request,
    output logic      o_tx_pending,
    output logic      o_switch_safe,
    output logic      o_rx_done
);
    logic [3:0] count_q;
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_tx_pending  <= 1'b0;
            o_switch_safe <= 1'b0;
            o_rx_done     <= 1'b0;
            count_q       <= 4'h0;
        end else begin
            o_switch_safe <= i_safe;
            o_rx_done     <= i_rx;
            if (i_load) begin
                o_tx_pending <= 1'b1;
            end
            // A slow abort, so the bit must stand for several cycles.
            if (i_abort_request && o_tx_pending) begin
                count_q <= count_q + 4'h1;
                if (count_q == 4'(ABORT_DELAY)) begin
                    o_tx_pending <= 1'b0;
                    count_q      <= 4'h0;
                end
            end
        end
    end
endmodule
